/* bvec_engine.sv */
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
module bvec_engine
   import bvec_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output bvec_mem_req_type mem_req,
   input wire logic mem_done,
   output bvec_pat_type pat_out
);

   typedef struct packed {
      // Bus side: write data phase, latched address, read data
      logic wr_pend;
      logic [15:0] addr;
      logic [31:0] rdata;
      // Master copies written by software
      logic [15:0] m_dx;
      logic [15:0] m_dy;
      logic [15:0] m_w;
      logic [15:0] m_h;
      logic [15:0] m_sx;
      logic [15:0] m_sy;
      logic [15:0] m_pc0;
      bvec_pat_mode_type m_pmode;
      logic [5:0] m_cmode;
      logic [3:0] m_lmode;
      logic m_vec;
      // Written since the last start, for the auto-update registers
      logic w_dx;
      logic w_dy;
      logic w_err;
      logic w_sy;
      // Operation queued in the masters
      logic pending;
      // Slave copies used by the running operation
      logic [15:0] s_dx;
      logic [15:0] s_dy;
      logic [15:0] s_w;
      logic [15:0] s_h;
      logic [15:0] s_sx;
      logic [15:0] s_sy;
      logic [15:0] s_pc0;
      bvec_pat_mode_type s_pmode;
      logic s_expand;
      logic [5:0] s_cmode;
      logic [3:0] s_lmode;
      logic s_vec;
      // Sequencer, count of lines or pixels, live positions and error
      bvec_state_type state;
      logic [15:0] cnt;
      logic [15:0] cx;
      logic [15:0] cy;
      logic [15:0] csy;
      logic [15:0] err;
   } bvec_regs_type;

   // Current and next state of the whole block
   bvec_regs_type r;
   bvec_regs_type next_r;

   // First request state of a scan line for the slave copy mode
   function automatic bvec_state_type bvec_line_first(input logic [5:0] cm);
      bvec_state_type st;
      st = BVEC_LINE;
      if (cm[BVEC_CM_SRC_LSB +: 2] == BVEC_TYPE_FB) begin
         st = BVEC_SRC;
      end else if (cm[BVEC_CM_DST_LSB +: 2] == BVEC_TYPE_FB) begin
         st = BVEC_DST;
      end
      return st;
   endfunction

   // Engine sequencing, then bus writes, then read capture
   always_comb begin
      logic [31:0] rd;
      logic [15:0] cnt1;
      logic minor;
      // Locals first, so nothing in here holds a stale value
      rd = BVEC_ZERO32;
      next_r = r;
      cnt1 = r.cnt + BVEC_STEP;
      minor = !r.err[15];

      case (r.state)
         BVEC_IDLE: begin
            if (r.pending) begin
               // Latch masters into slaves, auto-update ones only when written
               next_r.s_dx = r.w_dx ? r.m_dx : r.s_dx;
               next_r.s_dy = r.w_dy ? r.m_dy : r.s_dy;
               next_r.s_h = r.w_err ? r.m_h : r.s_h;
               next_r.s_sy = r.w_sy ? r.m_sy : r.s_sy;
               next_r.s_w = r.m_w;
               next_r.s_sx = r.m_sx;
               next_r.s_pc0 = r.m_pc0;
               next_r.s_pmode = r.m_pmode;
               next_r.s_expand = (r.m_pmode != BVEC_PAT_SOLID);
               next_r.s_cmode = r.m_cmode;
               next_r.s_lmode = r.m_lmode;
               next_r.s_vec = r.m_vec;
               // Written flags start afresh for the next queued operation
               next_r.w_dx = 1'b0;
               next_r.w_dy = 1'b0;
               next_r.w_err = 1'b0;
               next_r.w_sy = 1'b0;
               next_r.pending = 1'b0;
               // Walk starts at the slave positions and initial error
               next_r.cnt = BVEC_ZERO16;
               next_r.cx = next_r.s_dx;
               next_r.cy = next_r.s_dy;
               next_r.csy = next_r.s_sy;
               next_r.err = next_r.s_h;
               // Zero length or height finishes at once
               if (r.m_vec) begin
                  if (r.m_w == BVEC_ZERO16) begin
                     next_r.state = BVEC_FIN;
                  end else if (r.m_lmode[BVEC_LM_RDDST]) begin
                     next_r.state = BVEC_VRD;
                  end else begin
                     next_r.state = BVEC_VPIX;
                  end
               end else if (next_r.s_h == BVEC_ZERO16) begin
                  next_r.state = BVEC_FIN;
               end else begin
                  next_r.state = bvec_line_first(r.m_cmode);
               end
            end
         end
         BVEC_SRC: begin
            if (mem_done) begin
               // Source line landed; the destination line may follow
               if (r.s_cmode[BVEC_CM_DST_LSB +: 2] == BVEC_TYPE_FB) begin
                  next_r.state = BVEC_DST;
               end else begin
                  next_r.state = BVEC_LINE;
               end
            end
         end
         BVEC_DST: begin
            if (mem_done) begin
               // Destination line landed; render the line
               next_r.state = BVEC_LINE;
            end
         end
         BVEC_LINE: begin
            if (mem_done) begin
               // Advance one scan line in the copy direction
               next_r.cnt = cnt1;
               if (r.s_cmode[BVEC_CM_YNEG]) begin
                  next_r.cy = r.cy - BVEC_STEP;
                  next_r.csy = r.csy - BVEC_STEP;
               end else begin
                  next_r.cy = r.cy + BVEC_STEP;
                  next_r.csy = r.csy + BVEC_STEP;
               end
               // Last scan line ends the copy
               if (cnt1 == r.s_h) begin
                  next_r.state = BVEC_FIN;
               end else begin
                  next_r.state = bvec_line_first(r.s_cmode);
               end
            end
         end
         BVEC_VRD: begin
            if (mem_done) begin
               // Pixel held in buffer zero; render it next
               next_r.state = BVEC_VPIX;
            end
         end
         BVEC_VPIX: begin
            if (mem_done) begin
               // Bresenham step: major axis always, minor when error is not negative
               next_r.cnt = cnt1;
               if (r.s_lmode[BVEC_LM_YMAJOR] || minor) begin
                  next_r.cy = r.s_lmode[BVEC_LM_YNEG] ? r.cy - BVEC_STEP : r.cy + BVEC_STEP;
               end
               if (!r.s_lmode[BVEC_LM_YMAJOR] || minor) begin
                  next_r.cx = r.s_lmode[BVEC_LM_XNEG] ? r.cx - BVEC_STEP : r.cx + BVEC_STEP;
               end
               next_r.err = minor ? r.err + r.s_sy : r.err + r.s_sx;
               // Last pixel ends the vector, else read or draw the next one
               if (cnt1 == r.s_w) begin
                  next_r.state = BVEC_FIN;
               end else if (r.s_lmode[BVEC_LM_RDDST]) begin
                  next_r.state = BVEC_VRD;
               end else begin
                  next_r.state = BVEC_VPIX;
               end
            end
         end
         BVEC_FIN: begin
            // Leave updated slave values for a following operation
            if (r.s_vec) begin
               // Vector: continue from the next pixel with its error term
               next_r.s_dx = r.cx;
               next_r.s_dy = r.cy;
               next_r.s_h = r.err;
            end else if (r.s_cmode[BVEC_CM_EXPAND]) begin
               // Glyph: the next glyph sits one width to the right
               next_r.s_dx = r.s_dx + r.s_w;
            end else begin
               // Bitmap: the next copy sits one height further on
               next_r.s_dy = r.cy;
               if (r.s_cmode[BVEC_CM_SRC_LSB +: 2] != BVEC_TYPE_NONE) begin
                  next_r.s_sy = r.csy;
               end
            end
            next_r.state = BVEC_IDLE;
         end
         default: begin
            next_r.state = BVEC_IDLE;
         end
      endcase

      // Data phase of a bus write; line and copy mode writes queue an operation
      if (r.wr_pend) begin
         if (r.addr == BVEC_OFF_DST_XY) begin
            // Destination position; both halves count as written
            next_r.m_dx = hwdata[15:0];
            next_r.m_dy = hwdata[31:16];
            next_r.w_dx = 1'b1;
            next_r.w_dy = 1'b1;
         end else if (r.addr == BVEC_OFF_SIZE) begin
            // Width and height, or length and initial error
            next_r.m_w = hwdata[15:0];
            next_r.m_h = hwdata[31:16];
            next_r.w_err = 1'b1;
         end else if (r.addr == BVEC_OFF_SRC_XY) begin
            // Source position, or axial and diagonal error
            next_r.m_sx = hwdata[15:0];
            next_r.m_sy = hwdata[31:16];
            next_r.w_sy = 1'b1;
         end else if (r.addr == BVEC_OFF_PAT_COLOR0) begin
            // Colour used by solid primitives
            next_r.m_pc0 = hwdata[15:0];
         end else if (r.addr == BVEC_OFF_PAT_MODE) begin
            // Pattern kind for the next operation
            next_r.m_pmode = bvec_pat_mode_type'(hwdata[1:0]);
         end else if (r.addr == BVEC_OFF_LINE_MODE) begin
            // Vector direction and read flag; queues a vector
            next_r.m_lmode = hwdata[3:0];
            next_r.m_vec = 1'b1;
            next_r.pending = 1'b1;
         end else if (r.addr == BVEC_OFF_COPY_MODE) begin
            // Source and destination types; queues a copy
            next_r.m_cmode = hwdata[5:0];
            next_r.m_vec = 1'b0;
            next_r.pending = 1'b1;
         end
      end

      // Address phase: capture read data, registers as seen after this cycle's write, status as it stands before it
      // A write's data phase is the cycle after its address phase
      next_r.wr_pend = hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1]) begin
         next_r.addr = haddr[15:0];
      end
      // Unmapped offsets read as zero
      if (haddr[15:0] == BVEC_OFF_DST_XY) begin
         rd = {next_r.m_dy, next_r.m_dx};
      end else if (haddr[15:0] == BVEC_OFF_SIZE) begin
         rd = {next_r.m_h, next_r.m_w};
      end else if (haddr[15:0] == BVEC_OFF_SRC_XY) begin
         rd = {next_r.m_sy, next_r.m_sx};
      end else if (haddr[15:0] == BVEC_OFF_PAT_COLOR0) begin
         rd[15:0] = next_r.m_pc0;
      end else if (haddr[15:0] == BVEC_OFF_PAT_MODE) begin
         rd[1:0] = next_r.m_pmode;
      end else if (haddr[15:0] == BVEC_OFF_LINE_MODE) begin
         rd[3:0] = next_r.m_lmode;
      end else if (haddr[15:0] == BVEC_OFF_COPY_MODE) begin
         rd[5:0] = next_r.m_cmode;
      end else if (haddr[15:0] == BVEC_OFF_STATUS) begin
         // Busy while an operation runs, queued while one waits
         rd[BVEC_ST_BUSY] = (r.state != BVEC_IDLE);
         rd[BVEC_ST_QUEUED] = r.pending;
      end
      if (hsel && hready && htrans[1] && !hwrite) begin
         next_r.rdata = rd;
      end
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // Bus answers: zero wait states, always OKAY
   assign hrdata = r.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Memory request for the current state
   always_comb begin
      mem_req.valid = (r.state != BVEC_IDLE) && (r.state != BVEC_FIN);
      mem_req.kind = r.state;
      mem_req.src_expand = r.s_cmode[BVEC_CM_EXPAND];
      mem_req.buf_sel = (r.state == BVEC_SRC) ? BVEC_BUF_SRC : BVEC_BUF_DST;
      mem_req.x = (r.state == BVEC_SRC) ? r.s_sx : r.cx;
      mem_req.y = (r.state == BVEC_SRC) ? r.csy : r.cy;
      // Copies move whole lines, vectors one pixel at a time
      mem_req.len = r.s_vec ? BVEC_STEP : r.s_w;
   end

   // Pattern source: solid uses colour zero with expansion off
   // These follow the slave copies, so they change only at a start
   assign pat_out.expand_en = r.s_expand;
   assign pat_out.mode = r.s_pmode;
   assign pat_out.color_zero = r.s_pc0;

endmodule

/* bvec_engine_properties.sv */
`timescale 1ns/1ps
module bvec_engine_properties
   import bvec_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire bvec_mem_req_type mem_req,
   input wire logic mem_done,
   input wire bvec_pat_type pat_out
);
   logic st_rd;
   logic valid_q;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Marks the data phase of a status read and the request state it reflects
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_rd <= 1'b0;
         valid_q <= 1'b0;
      end else begin
         st_rd <= hsel && hready && htrans[1] && !hwrite && haddr[15:0] == BVEC_OFF_STATUS;
         valid_q <= mem_req.valid;
      end
   end
   // Bus answer, pattern output, request shape and order
   property p_bus_okay; hreadyout && !hresp; endproperty
   a_bus_okay: assert property (p_bus_okay) else $error("bus answer not OKAY");
   property p_solid_plain; pat_out.mode == BVEC_PAT_SOLID |-> !pat_out.expand_en; endproperty
   a_solid_plain: assert property (p_solid_plain) else $error("solid expands");
   property p_pat_expand; pat_out.mode != BVEC_PAT_SOLID |-> pat_out.expand_en; endproperty
   a_pat_expand: assert property (p_pat_expand) else $error("pattern not expanded");
   property p_fetch_buf;
      mem_req.valid && (mem_req.kind == BVEC_SRC || mem_req.kind == BVEC_DST) |->
         mem_req.buf_sel == ((mem_req.kind == BVEC_SRC) ? BVEC_BUF_SRC : BVEC_BUF_DST);
   endproperty
   a_fetch_buf: assert property (p_fetch_buf) else $error("fetch buffer wrong");
   property p_rd_buf;
      mem_req.valid && mem_req.kind == BVEC_VRD |->
         mem_req.buf_sel == BVEC_BUF_DST && mem_req.len == BVEC_STEP;
   endproperty
   a_rd_buf: assert property (p_rd_buf) else $error("vector read buffer wrong");
   property p_rd_then_pix;
      mem_req.valid && mem_req.kind == BVEC_VRD && mem_done |=>
         mem_req.valid && mem_req.kind == BVEC_VPIX;
   endproperty
   a_rd_then_pix: assert property (p_rd_then_pix) else $error("no pixel after read");
   property p_pix_len; mem_req.valid && mem_req.kind == BVEC_VPIX |-> mem_req.len == BVEC_STEP;
   endproperty
   a_pix_len: assert property (p_pix_len) else $error("pixel length wrong");
   property p_src_next;
      mem_req.valid && mem_req.kind == BVEC_SRC && mem_done |=>
         mem_req.valid && (mem_req.kind == BVEC_DST || mem_req.kind == BVEC_LINE);
   endproperty
   a_src_next: assert property (p_src_next) else $error("source fetch not followed");
   property p_req_hold; mem_req.valid && !mem_done |=> $stable(mem_req); endproperty
   a_req_hold: assert property (p_req_hold) else $error("request changed early");
   property p_busy_seen; st_rd && valid_q |-> hrdata[BVEC_ST_BUSY]; endproperty
   a_busy_seen: assert property (p_busy_seen) else $error("busy missing");
   // Main scenarios reached
   c_vec_read: cover property (mem_req.valid && mem_req.kind == BVEC_VRD && mem_done);
   c_src_fetch: cover property (mem_req.valid && mem_req.kind == BVEC_SRC && mem_done);
   c_queued: cover property (st_rd && hrdata[BVEC_ST_QUEUED]);
endmodule

bind bvec_engine bvec_engine_properties chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req), .mem_done(mem_done),
   .pat_out(pat_out));

/* bvec_engine_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module bvec_engine_tb
   import bvec_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, mem_done;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [15:0] r0l, r0h, r4l, r4h, r8l, r8h, col;
   logic [3:0] lm;
   logic [51:0] want, got;
   logic [51:0] exq[$];
   logic [5:0] cms [5] = '{6'h05, 6'h05, 6'h24, 6'h12, 6'h0a};
   bvec_mem_req_type mem_req;
   bvec_pat_type pat_out;
   int failures, checked, seed;
   assign hready = hreadyout;
   // Free running clock
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   bvec_engine dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req),
      .mem_done(mem_done), .pat_out(pat_out));
   task automatic test_done;
      if (failures == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // One single AHB transfer, held until hready is seen at each phase
   task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= {16'h0000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hwdata <= wr ? d : $random(seed);
      do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
      rd = hrdata;
      if (n >= 100) begin failures++; test_done; end
   endtask
   // Register write that also updates the model's master copies
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      case (a)
         BVEC_OFF_DST_XY: {r0h, r0l} = d;
         BVEC_OFF_SIZE: {r4h, r4l} = d;
         BVEC_OFF_SRC_XY: {r8h, r8l} = d;
         default: ;
      endcase
   endtask
   // Vector model: pixel requests and continuation values
   task automatic vec(input logic [3:0] m);
      logic stx;
      logic sty;
      for (int i = 0; i < r4l; i++) begin
         if (m[BVEC_LM_RDDST]) exq.push_back({BVEC_VRD, 1'b0, r0l, r0h, BVEC_STEP});
         exq.push_back({BVEC_VPIX, 1'b0, r0l, r0h, BVEC_STEP});
         stx = !m[BVEC_LM_YMAJOR] || !r4h[15];
         sty = m[BVEC_LM_YMAJOR] || !r4h[15];
         if (stx) r0l = m[BVEC_LM_XNEG] ? r0l - BVEC_STEP : r0l + BVEC_STEP;
         if (sty) r0h = m[BVEC_LM_YNEG] ? r0h - BVEC_STEP : r0h + BVEC_STEP;
         r4h = r4h[15] ? r4h + r8l : r4h + r8h;
      end
   endtask
   // Copy model: per line fetches then render, then automatic updates
   task automatic cp(input logic [5:0] cm);
      logic [15:0] d;
      logic [15:0] lo;
      logic e;
      d = cm[BVEC_CM_YNEG] ? 16'hffff : BVEC_STEP;
      lo = BVEC_ZERO16;
      e = cm[BVEC_CM_EXPAND];
      for (int l = 0; l < r4h; l++) begin
         if (cm[1:0] == BVEC_TYPE_FB) exq.push_back({BVEC_SRC, e, r8l, r8h + lo, r4l});
         if (cm[3:2] == BVEC_TYPE_FB) exq.push_back({BVEC_DST, e, r0l, r0h + lo, r4l});
         exq.push_back({BVEC_LINE, e, r0l, r0h + lo, r4l});
         lo = lo + d;
      end
      if (cm[BVEC_CM_EXPAND]) r0l = r0l + r4l;
      else begin
         r0h = r0h + lo;
         if (cm[1:0] != BVEC_TYPE_NONE) r8h = r8h + lo;
      end
   endtask
   // Waits for the model queue to drain, then expects an idle status
   task automatic settle;
      int n;
      n = 0;
      while ((exq.size() != 0 || mem_req.valid !== 1'b0) && n < 3000) begin
         @(posedge hclk);
         n++;
      end
      if (n >= 3000) begin failures++; test_done; end
      repeat (2) @(posedge hclk);
      bus(1'b0, BVEC_OFF_STATUS, BVEC_ZERO32);
      `CHK({rd[BVEC_ST_QUEUED], rd[BVEC_ST_BUSY]}, 2'b00)
   endtask
   // Memory side: random completion, each request checked against the model
   always @(posedge hclk) begin
      if (hresetn === 1'b1 && mem_done === 1'b1 && mem_req.valid === 1'b1) begin
         want = (exq.size() > 0) ? exq.pop_front() : '1;
         got = {mem_req.kind, mem_req.src_expand, mem_req.x, mem_req.y, mem_req.len};
         `CHK(got, want)
      end
      mem_done <= 1'($random(seed));
   end
   // Main sequence
   initial begin
      seed = 32'h092c_3824;
      failures = 0;
      checked = 0;
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      {r0l, r0h, r4l, r4h, r8l, r8h} = '0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(1'b0, BVEC_OFF_STATUS, BVEC_ZERO32);
      `CHK(rd, BVEC_ZERO32)
      wr(16'h8300, 32'h1234_5678);
      bus(1'b0, BVEC_OFF_STATUS, BVEC_ZERO32);
      `CHK(rd, BVEC_ZERO32)
      bus(1'b0, 16'h8300, BVEC_ZERO32);
      `CHK(rd, BVEC_ZERO32)
      wr(BVEC_OFF_DST_XY, 32'h0064_0064);
      wr(BVEC_OFF_SIZE, 32'hffff_0003);
      wr(BVEC_OFF_SRC_XY, 32'hfffb_0002);
      for (int i = 0; i < 8; i++) begin
         col = 16'($random(seed));
         wr(BVEC_OFF_PAT_MODE, {30'h0, i[1:0]});
         wr(BVEC_OFF_PAT_COLOR0, {16'h0000, col});
         lm = {i[1] ^ i[0], i[2:0]};
         wr(BVEC_OFF_LINE_MODE, {28'h0, lm});
         vec(lm);
         settle;
         bus(1'b0, BVEC_OFF_LINE_MODE, BVEC_ZERO32);
         `CHK(rd[3:0], lm)
         `CHK(pat_out, {i[1:0] != 2'h0, i[1:0], col})
      end
      wr(BVEC_OFF_DST_XY, 32'h0020_0010);
      wr(BVEC_OFF_SIZE, 32'h0002_0004);
      wr(BVEC_OFF_SRC_XY, 32'h0040_0008);
      for (int k = 0; k < 5; k++) begin
         wr(BVEC_OFF_COPY_MODE, {26'h0, cms[k]});
         cp(cms[k]);
         settle;
      end
      // Second copy queued behind the running one
      wr(BVEC_OFF_COPY_MODE, 32'h0000_0005);
      cp(6'h05);
      wr(BVEC_OFF_COPY_MODE, 32'h0000_0005);
      cp(6'h05);
      bus(1'b0, BVEC_OFF_STATUS, BVEC_ZERO32);
      `CHK({rd[BVEC_ST_QUEUED], rd[BVEC_ST_BUSY]}, 2'b11)
      settle;
      test_done;
   end
endmodule

/* bvec_pkg.sv */
package bvec_pkg;
   // Register byte offsets within the engine window
   localparam logic [15:0] BVEC_OFF_DST_XY = 16'h8100;
   localparam logic [15:0] BVEC_OFF_SIZE = 16'h8104;
   localparam logic [15:0] BVEC_OFF_SRC_XY = 16'h8108;
   localparam logic [15:0] BVEC_OFF_PAT_COLOR0 = 16'h8110;
   localparam logic [15:0] BVEC_OFF_PAT_MODE = 16'h8114;
   localparam logic [15:0] BVEC_OFF_LINE_MODE = 16'h8204;
   localparam logic [15:0] BVEC_OFF_COPY_MODE = 16'h8208;
   localparam logic [15:0] BVEC_OFF_STATUS = 16'h820c;

   // Copy mode fields
   localparam int BVEC_CM_SRC_LSB = 0;
   localparam int BVEC_CM_DST_LSB = 2;
   localparam int BVEC_CM_EXPAND = 4;
   localparam int BVEC_CM_YNEG = 5;
   localparam logic [1:0] BVEC_TYPE_NONE = 2'h0;
   localparam logic [1:0] BVEC_TYPE_FB = 2'h1;
   localparam logic [1:0] BVEC_TYPE_BUF = 2'h2;

   // Line mode fields
   localparam int BVEC_LM_YMAJOR = 0;
   localparam int BVEC_LM_XNEG = 1;
   localparam int BVEC_LM_YNEG = 2;
   localparam int BVEC_LM_RDDST = 3;

   // Status fields
   localparam int BVEC_ST_BUSY = 0;
   localparam int BVEC_ST_QUEUED = 2;

   // Reset values and steps
   localparam logic [15:0] BVEC_ZERO16 = 16'h0000;
   localparam logic [15:0] BVEC_STEP = 16'h0001;
   localparam logic [31:0] BVEC_ZERO32 = 32'h0000_0000;

   // Staging buffer indices
   localparam logic BVEC_BUF_DST = 1'b0;
   localparam logic BVEC_BUF_SRC = 1'b1;

   typedef enum logic [1:0] {
      BVEC_PAT_SOLID = 2'b00,
      BVEC_PAT_MONO = 2'b01,
      BVEC_PAT_DITHER = 2'b10,
      BVEC_PAT_COLOR = 2'b11
   } bvec_pat_mode_type;

   typedef enum logic [2:0] {
      BVEC_IDLE = 3'b000,
      BVEC_SRC = 3'b001,
      BVEC_DST = 3'b010,
      BVEC_LINE = 3'b011,
      BVEC_VRD = 3'b100,
      BVEC_VPIX = 3'b101,
      BVEC_FIN = 3'b110
   } bvec_state_type;

   typedef struct packed {
      logic valid;
      bvec_state_type kind;
      logic buf_sel;
      logic src_expand;
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] len;
   } bvec_mem_req_type;

   typedef struct packed {
      logic expand_en;
      bvec_pat_mode_type mode;
      logic [15:0] color_zero;
   } bvec_pat_type;
endpackage
